// ---- include/lcap_pkg.sv ----
// Shared types and constants for the command, address and write-mask port.
// Assumes one 100 MHz system clock samples all memory-side pins.
package lcap_pkg;

  localparam int unsigned ADDR_W_X16    = 13;
  localparam int unsigned ADDR_W_X32    = 14;
  localparam int unsigned ADDR_W_MAX    = 14;
  localparam int unsigned PRE_FLAG_POS  = 10;
  localparam int unsigned BANK_W        = 2;
  localparam int unsigned LANES_MAX     = 4;
  localparam logic [3:0]  CMD_RST_VAL   = 4'hf;

  // Command code: chip select, row strobe, column strobe, write enable (all active low).
  typedef enum logic [3:0] {
    LCAP_CMD_MRS   = 4'b0000,
    LCAP_CMD_REF   = 4'b0001,
    LCAP_CMD_PRE   = 4'b0010,
    LCAP_CMD_ACT   = 4'b0011,
    LCAP_CMD_WR    = 4'b0100,
    LCAP_CMD_RD    = 4'b0101,
    LCAP_CMD_BST   = 4'b0110,
    LCAP_CMD_NOP   = 4'b0111,
    LCAP_CMD_DESEL = 4'b1111
  } lcap_cmd_type;

  typedef enum logic [1:0] {
    LCAP_PWR_ACTIVE = 2'b00,
    LCAP_PWR_PPD    = 2'b01,
    LCAP_PWR_APD    = 2'b10,
    LCAP_PWR_SREF   = 2'b11
  } lcap_pwr_type;

  typedef struct packed {
    logic                  valid;
    lcap_cmd_type          cmd;
    logic [BANK_W-1:0]     bank;
    logic [ADDR_W_MAX-1:0] addr;
    logic                  auto_pre;
    logic                  pre_all;
    logic [3:0]            bank_onehot;
  } lcap_dec_type;

endpackage

// ---- core/lcap_sync3.sv ----
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes the input is a plain level from outside the clock domain.
`timescale 1ns/1ps
module lcap_sync3 #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic mclk_in,
  input  wire logic arst_n_in,
  input  wire logic d_in,
  output logic      q_out
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1_q  <= RST_VAL;
      s2_q  <= RST_VAL;
      s3_q  <= RST_VAL;
      q_out <= RST_VAL;
    end else begin
      s1_q <= d_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // A change counts only once the second and third stages agree.
      if (s2_q == s3_q) begin
        q_out <= s3_q;
      end
    end
  end
endmodule // lcap_sync3

// ---- core/lcap_lane_mask.sv ----
// One byte lane's write-mask capture on both strobe edges.
// Assumes strobe and mask are already synchronised to the system clock.
`timescale 1ns/1ps
module lcap_lane_mask (
  input  wire logic mclk_in,
  input  wire logic arst_n_in,
  input  wire logic enable_in,
  input  wire logic strobe_in,
  input  wire logic mask_in,
  output logic      beat_out,
  output logic      keep_out
);
  logic strobe_q;

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      strobe_q <= 1'b0;
      beat_out <= 1'b0;
      keep_out <= 1'b0;
    end else begin
      strobe_q <= strobe_in;
      // Either strobe edge is one data beat; the mask is sampled with it.
      beat_out <= enable_in && (strobe_in != strobe_q);  // [R10]
      keep_out <= enable_in && (strobe_in != strobe_q) && !mask_in;  // [R9]
    end
  end
endmodule // lcap_lane_mask

// ---- core/lcap_port.sv ----
// Command, address and write-mask front end of a low-power DDR memory.
// Assumes the controller drives every pin; all pins arrive asynchronous
// to mclk_in; all but read_strobe_drive_in and sref_request_in are synchronised here before use.
`timescale 1ns/1ps
// Function
// (R1) Register address and control on rising true clock.
// (R2) Data uses both clock crossing directions.
// (R3) Clock enable high runs clocks, buffers, drivers.
// (R4) Enable low: idle gives precharge/self refresh, else active.
// (R5) Enable sampled on clock except self refresh exit.
// (R6) Low power disables all buffers except enable.
// (R7) Chip select high masks every command.
// (R8) Strobes plus chip select define command.
// (R9) Masked write bytes are discarded.
// (R10) Masks sampled on both strobe edges.
// (R11) Bank select picks bank for commands.
// (R12) Bank select picks mode register on load.
// (R13) Address: row on activate, column plus auto precharge.
// (R14) Precharge flag low one bank, high all.
// (R15) Mode load takes op-code from address.
// (R16) Address 13 or 14 bits; unused lines reserved.
// (R17) Lane strobe: device on read, controller on write.
module lcap_port
  import lcap_pkg::*;
#(
  parameter bit          WIDE_X32 = 1'b0,
  parameter int unsigned LANES    = 2
) (
  input  wire logic                  mclk_in,
  input  wire logic                  arst_n_in,
  input  wire logic                  clock_true_in,
  input  wire logic                  clock_complement_in,
  input  wire logic                  clk_en_in,
  input  wire logic                  chip_sel_n_in,
  input  wire logic                  row_strobe_n_in,
  input  wire logic                  col_strobe_n_in,
  input  wire logic                  write_en_n_in,
  input  wire logic                  bank_sel_lo_in,
  input  wire logic                  bank_sel_hi_in,
  input  wire logic [ADDR_W_MAX-1:0] addr_in,
  input  wire logic [LANES-1:0]      lane_write_masks_in,
  input  wire logic [LANES-1:0]      lane_strobe_in,
  input  wire logic [LANES-1:0]      read_strobe_drive_in,
  input  wire logic                  sref_request_in,
  output logic                       cmd_valid_out,
  output lcap_cmd_type               cmd_out,
  output logic [BANK_W-1:0]          bank_out,
  output logic [ADDR_W_MAX-1:0]      addr_out,
  output logic                       auto_pre_out,
  output logic                       pre_all_out,
  output logic [3:0]                 pre_banks_out,
  output logic                       mode_load_out,
  output logic [BANK_W-1:0]          mode_sel_out,
  output logic [ADDR_W_MAX-1:0]      mode_opcode_out,
  output logic [3:0]                 open_banks_out,
  output lcap_pwr_type               pwr_state_out,
  output logic                       clocks_run_out,
  output logic                       drivers_on_out,
  output logic [LANES-1:0]           lane_beat_out,
  output logic [LANES-1:0]           lane_keep_out,
  output logic [LANES-1:0]           lane_strobe_out,
  output logic [LANES-1:0]           lane_strobe_oe_out,
  output logic                       data_edge_out
);

  localparam int unsigned ADDR_W = WIDE_X32 ? ADDR_W_X32 : ADDR_W_X16;
  localparam int unsigned NPINS  = 8 + ADDR_W_MAX;

  // Clock, enable, command, low bank select and address pins, packed so one synchroniser generate covers them all.
  logic [NPINS-1:0] pins_raw;
  logic [NPINS-1:0] pins_s;
  logic             ck_s;
  logic             ckb_s;
  logic             cke_s;
  logic             ck_q;
  logic             cross_q;

  logic [LANES-1:0] strobe_s;
  logic [LANES-1:0] mask_s;

  lcap_pwr_type     pwr_q;
  lcap_pwr_type     pwr_d;
  logic [3:0]       open_q;
  logic [3:0]       open_d;
  logic             buffers_on;
  logic             rise_edge;
  logic             fall_edge;
  logic             sref_async_exit_q;
  logic             cke_n_raw_q;
  lcap_dec_type     dec;
  logic [3:0]       bank_hot;

  assign pins_raw = {clock_true_in, clock_complement_in, clk_en_in, chip_sel_n_in, row_strobe_n_in,
                     col_strobe_n_in, write_en_n_in, bank_sel_lo_in ^ 1'b0, addr_in};

  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_pin_sync
      lcap_sync3 #(.RST_VAL(1'b0)) u_sync (
        .mclk_in   (mclk_in),
        .arst_n_in (arst_n_in),
        .d_in      (pins_raw[gi]),
        .q_out     (pins_s[gi])
      );
    end
    for (gi = 0; gi < LANES; gi++) begin : g_lane
      lcap_sync3 #(.RST_VAL(1'b0)) u_strobe_sync (
        .mclk_in   (mclk_in),
        .arst_n_in (arst_n_in),
        .d_in      (lane_strobe_in[gi]),
        .q_out     (strobe_s[gi])
      );
      lcap_sync3 #(.RST_VAL(1'b0)) u_mask_sync (
        .mclk_in   (mclk_in),
        .arst_n_in (arst_n_in),
        .d_in      (lane_write_masks_in[gi]),
        .q_out     (mask_s[gi])
      );
      lcap_lane_mask u_mask (
        .mclk_in   (mclk_in),
        .arst_n_in (arst_n_in),
        .enable_in (buffers_on && !read_strobe_drive_in[gi]),  // [R6] [R17]
        .strobe_in (strobe_s[gi]),
        .mask_in   (mask_s[gi]),
        .beat_out  (lane_beat_out[gi]),
        .keep_out  (lane_keep_out[gi])
      );
    end
  endgenerate

  // The high bank select bit takes its own synchroniser.
  logic bank_hi_s;
  lcap_sync3 #(.RST_VAL(1'b0)) u_bank_hi_sync (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .d_in      (bank_sel_hi_in),
    .q_out     (bank_hi_s)
  );

  assign ck_s  = pins_s[NPINS-1];
  assign ckb_s = pins_s[NPINS-2];
  assign cke_s = pins_s[NPINS-3];

  // Crossing state: true above complement. Differential compare rejects
  // a single leg glitch that a plain edge detector would accept.
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ck_q    <= 1'b0;
      cross_q <= 1'b0;
    end else begin
      cross_q <= ck_s & ~ckb_s;
      ck_q    <= cross_q;
    end
  end

  assign rise_edge  = cross_q & ~ck_q;  // [R1]
  assign fall_edge  = ~cross_q & ck_q;
  assign buffers_on = (pwr_q == LCAP_PWR_ACTIVE);  // [R3] [R6]

  // Command decode at the rising crossing, only while buffers are live.
  always_comb begin
    dec          = '0;
    dec.cmd      = LCAP_CMD_DESEL;
    bank_hot     = 4'h0;
    bank_hot[{bank_hi_s, pins_s[ADDR_W_MAX]}] = 1'b1;  // [R11]
    if (rise_edge && buffers_on && cke_s) begin
      if (pins_s[NPINS-4]) begin
        dec.cmd = LCAP_CMD_DESEL;  // [R7]
      end else begin
        dec.cmd   = lcap_cmd_type'(pins_s[NPINS-4:NPINS-7]);  // [R8]
        dec.valid = (dec.cmd != LCAP_CMD_NOP);
      end
      dec.bank = {bank_hi_s, pins_s[ADDR_W_MAX]};
      // Reserved upper lines of the narrow variant are forced low.
      dec.addr = pins_s[ADDR_W_MAX-1:0] & ADDR_W_MAX'((1 << ADDR_W) - 1);  // [R16]
      if (dec.cmd == LCAP_CMD_RD || dec.cmd == LCAP_CMD_WR) begin
        dec.auto_pre = dec.addr[PRE_FLAG_POS];  // [R13]
      end
      if (dec.cmd == LCAP_CMD_PRE) begin
        dec.pre_all     = dec.addr[PRE_FLAG_POS];  // [R14]
        dec.bank_onehot = dec.addr[PRE_FLAG_POS] ? 4'hf : bank_hot;  // [R14]
      end
    end
  end

  // Open-row bookkeeping drives the power-down choice.
  always_comb begin
    open_d = open_q;
    if (dec.valid && dec.cmd == LCAP_CMD_ACT) begin
      open_d = open_q | bank_hot;
    end
    if (dec.valid && dec.cmd == LCAP_CMD_PRE) begin
      open_d = open_q & ~dec.bank_onehot;
    end
    if (dec.valid && dec.auto_pre) begin
      open_d = open_q & ~bank_hot;
    end
  end

  // Exit from self refresh is timed by the system clock, never by the memory
  // clock, which the controller may have stopped; this flag arms on enable low.
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cke_n_raw_q <= 1'b0;
    end else begin
      cke_n_raw_q <= (pwr_q == LCAP_PWR_SREF) && !cke_s;  // [R5]
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sref_async_exit_q <= 1'b0;
    end else begin
      sref_async_exit_q <= cke_n_raw_q && cke_s;
    end
  end

  always_comb begin
    pwr_d = pwr_q;
    unique case (pwr_q)
      LCAP_PWR_ACTIVE: begin
        if (rise_edge && !cke_s) begin  // [R5]
          if (open_q != 4'h0) begin
            pwr_d = LCAP_PWR_APD;  // [R4]
          end else if (sref_request_in) begin
            pwr_d = LCAP_PWR_SREF;  // [R4]
          end else begin
            pwr_d = LCAP_PWR_PPD;  // [R4]
          end
        end
      end
      LCAP_PWR_PPD, LCAP_PWR_APD: begin
        if (rise_edge && cke_s) begin
          pwr_d = LCAP_PWR_ACTIVE;
        end
      end
      LCAP_PWR_SREF: begin
        if (sref_async_exit_q || cke_s) begin
          pwr_d = LCAP_PWR_ACTIVE;  // [R5]
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pwr_q  <= LCAP_PWR_ACTIVE;
      open_q <= 4'h0;
    end else begin
      pwr_q  <= pwr_d;
      open_q <= open_d;
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cmd_valid_out   <= 1'b0;
      cmd_out         <= LCAP_CMD_DESEL;
      bank_out        <= '0;
      addr_out        <= '0;
      auto_pre_out    <= 1'b0;
      pre_all_out     <= 1'b0;
      pre_banks_out   <= 4'h0;
      mode_load_out   <= 1'b0;
      mode_sel_out    <= '0;
      mode_opcode_out <= '0;
    end else begin
      cmd_valid_out <= dec.valid;
      cmd_out       <= dec.cmd;
      bank_out      <= dec.bank;
      addr_out      <= dec.addr;
      auto_pre_out  <= dec.auto_pre;
      pre_all_out   <= dec.pre_all;
      pre_banks_out <= dec.bank_onehot;
      mode_load_out <= dec.valid && dec.cmd == LCAP_CMD_MRS;
      if (dec.valid && dec.cmd == LCAP_CMD_MRS) begin
        mode_sel_out    <= dec.bank;  // [R12]
        mode_opcode_out <= dec.addr;  // [R15]
      end
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      open_banks_out     <= 4'h0;
      pwr_state_out      <= LCAP_PWR_ACTIVE;
      clocks_run_out     <= 1'b0;
      drivers_on_out     <= 1'b0;
      lane_strobe_out    <= '0;
      lane_strobe_oe_out <= '0;
      data_edge_out      <= 1'b0;
    end else begin
      open_banks_out     <= open_q;
      pwr_state_out      <= pwr_q;
      clocks_run_out     <= buffers_on;  // [R3]
      drivers_on_out     <= buffers_on;  // [R3]
      // Device drives strobe only with read data, edge aligned to the clock.
      lane_strobe_oe_out <= buffers_on ? read_strobe_drive_in : '0;  // [R17]
      lane_strobe_out    <= {LANES{cross_q}};  // [R17]
      data_edge_out      <= buffers_on && (rise_edge || fall_edge);  // [R2]
    end
  end

endmodule // lcap_port

// ---- tb/lcap_port_chk.sv ----
// Checker for the command port: ties decoded outputs to their causes.
// Assumes it is bound to every lcap_port instance.
`timescale 1ns/1ps
module lcap_port_chk
  import lcap_pkg::*;
#(
  parameter int unsigned LANES = 2
) (
  input wire logic                  mclk_in,
  input wire logic                  arst_n_in,
  input wire logic                  cmd_valid_out,
  input wire lcap_cmd_type          cmd_out,
  input wire logic [BANK_W-1:0]     bank_out,
  input wire logic [ADDR_W_MAX-1:0] addr_out,
  input wire logic                  auto_pre_out,
  input wire logic                  pre_all_out,
  input wire logic [3:0]            pre_banks_out,
  input wire logic                  mode_load_out,
  input wire logic [BANK_W-1:0]     mode_sel_out,
  input wire logic [ADDR_W_MAX-1:0] mode_opcode_out,
  input wire logic [3:0]            open_banks_out,
  input wire lcap_pwr_type          pwr_state_out,
  input wire logic                  clocks_run_out,
  input wire logic                  drivers_on_out,
  input wire logic [LANES-1:0]      lane_beat_out,
  input wire logic [LANES-1:0]      lane_keep_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  AST_CS_MASK: assert property (
    cmd_valid_out |-> !cmd_out[3]) else $error("command decoded with chip select high");
  AST_NO_NOP: assert property (
    cmd_valid_out |-> cmd_out != LCAP_CMD_NOP) else $error("idle code reported as command");
  AST_AUTO_PRE: assert property (
    cmd_valid_out && cmd_out inside {LCAP_CMD_RD, LCAP_CMD_WR} |-> auto_pre_out == addr_out[PRE_FLAG_POS])
    else $error("auto precharge flag wrong");
  AST_PRE_SET: assert property (
    cmd_valid_out && cmd_out == LCAP_CMD_PRE |-> pre_all_out == addr_out[PRE_FLAG_POS] &&
    pre_banks_out == (pre_all_out ? 4'hf : 4'h1 << bank_out)) else $error("precharge bank set wrong");
  AST_PRE_CLOSE: assert property (
    cmd_valid_out && cmd_out == LCAP_CMD_PRE |=> (open_banks_out & $past(pre_banks_out)) == 4'h0)
    else $error("precharged bank still open");
  AST_MODE_HOLD: assert property (
    $changed({mode_sel_out, mode_opcode_out}) |-> mode_load_out || $past(mode_load_out))
    else $error("mode outputs changed without a load");
  AST_GATED: assert property (
    pwr_state_out != LCAP_PWR_ACTIVE && $past(pwr_state_out) != LCAP_PWR_ACTIVE |->
    !clocks_run_out && !drivers_on_out) else $error("clocks or drivers running in low power");
  AST_PD_KIND: assert property (
    pwr_state_out != LCAP_PWR_ACTIVE |-> (pwr_state_out == LCAP_PWR_APD) == (open_banks_out != 4'h0))
    else $error("power-down kind does not match open rows");
  AST_IGNORE: assert property (
    $past(pwr_state_out, 8) != LCAP_PWR_ACTIVE && pwr_state_out != LCAP_PWR_ACTIVE |-> !cmd_valid_out)
    else $error("command taken in low power");
  AST_KEEP_BEAT: assert property (
    lane_keep_out != '0 |-> (lane_keep_out & ~lane_beat_out) == '0) else $error("byte kept without a beat");
endmodule // lcap_port_chk

bind lcap_port lcap_port_chk #(.LANES(LANES)) lcap_port_chk_inst (
  .mclk_in, .arst_n_in, .cmd_valid_out, .cmd_out, .bank_out, .addr_out, .auto_pre_out, .pre_all_out,
  .pre_banks_out, .mode_load_out, .mode_sel_out, .mode_opcode_out, .open_banks_out, .pwr_state_out,
  .clocks_run_out, .drivers_on_out, .lane_beat_out, .lane_keep_out);

// ---- tb/lcap_ctrl_model.sv ----
// Controller model: makes the memory clock and drives command pins.
// Assumes the bench calls issue() for one command at a time.
`timescale 1ns/1ps
module lcap_ctrl_model
  import lcap_pkg::*;
(
  output logic                  ck_t_out,
  output logic                  ck_c_out,
  output logic [3:0]            cmd_out,
  output logic [BANK_W-1:0]     bank_out,
  output logic [ADDR_W_MAX-1:0] addr_out
);
  // One eighth of the system rate, offset so no crossing lands on a system edge.
  initial begin
    ck_t_out = 1'b0;
    cmd_out = CMD_RST_VAL;
    bank_out = '0;
    addr_out = '0;
    #3;
    forever #40 ck_t_out = ~ck_t_out;
  end
  assign ck_c_out = ~ck_t_out;
  // Pins change at the falling crossing, so they are settled at the rising one.
  task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [13:0] a);
    @(negedge ck_t_out);
    cmd_out = c;
    bank_out = b;
    addr_out = a;
    @(negedge ck_t_out);
    cmd_out = CMD_RST_VAL;
    bank_out = ~b;
    addr_out = ~a;
  endtask
endmodule // lcap_ctrl_model

// ---- tb/tb_top.sv ----
// Self-checking bench for lcap_port driven by a controller model.
// Assumes the default x16 port with two byte lanes.
`timescale 1ns/1ps
module tb_top;
  import lcap_pkg::*;
  logic mclk_in, arst_n_in, clk_en_in, sref_request_in, ck_t, ck_c;
  logic [3:0] pins, pre_banks_out, open_banks_out;
  logic [1:0] bank_pins, bank_out, mode_sel_out, masks, strobes, rd_drive, beat, keep, s_out, s_oe;
  logic [13:0] addr_pins, addr_out, mode_opcode_out;
  logic cmd_valid_out, auto_pre_out, pre_all_out, mode_load_out, clocks_run_out, drivers_on_out, data_edge_out;
  lcap_cmd_type cmd_out;
  lcap_pwr_type pwr_state_out;
  int fails, n_compared, cycles, n_edge, n_sedge;
  int beats [2];
  int keeps [2];
  logic got_v, got_m, s_last;
  logic [25:0] snap;

  lcap_ctrl_model lcap_ctrl_model_inst (.ck_t_out(ck_t), .ck_c_out(ck_c), .cmd_out(pins), .bank_out(bank_pins),
    .addr_out(addr_pins));
  lcap_port lcap_port_inst (.mclk_in, .arst_n_in, .clock_true_in(ck_t), .clock_complement_in(ck_c), .clk_en_in,
    .chip_sel_n_in(pins[3]), .row_strobe_n_in(pins[2]), .col_strobe_n_in(pins[1]), .write_en_n_in(pins[0]),
    .bank_sel_lo_in(bank_pins[0]), .bank_sel_hi_in(bank_pins[1]), .addr_in(addr_pins),
    .lane_write_masks_in(masks), .lane_strobe_in(strobes), .read_strobe_drive_in(rd_drive), .sref_request_in,
    .cmd_valid_out, .cmd_out, .bank_out, .addr_out, .auto_pre_out, .pre_all_out, .pre_banks_out, .mode_load_out,
    .mode_sel_out, .mode_opcode_out, .open_banks_out, .pwr_state_out, .clocks_run_out, .drivers_on_out,
    .lane_beat_out(beat), .lane_keep_out(keep), .lane_strobe_out(s_out), .lane_strobe_oe_out(s_oe),
    .data_edge_out);

  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    n_edge <= n_edge + data_edge_out;
    s_last <= s_out[0];
    n_sedge <= n_sedge + int'(s_out[0] != s_last);
    for (int i = 0; i < 2; i++) begin
      beats[i] <= beats[i] + beat[i];
      keeps[i] <= keeps[i] + keep[i];
    end
    if (cycles == 3000) begin
      fails++;
      final_report;
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask

  // Output pulses stand one cycle, so every cycle of the answer window is looked at.
  task automatic send(input logic [3:0] c, input logic [1:0] b, input logic [13:0] a);
    got_v = 1'b0;
    got_m = 1'b0;
    lcap_ctrl_model_inst.issue(c, b, a);
    repeat (16) begin
      tick(1);
      if (cmd_valid_out === 1'b1 && !got_v)
        snap = {cmd_out, bank_out, addr_out, auto_pre_out, pre_all_out, pre_banks_out};
      got_v |= cmd_valid_out === 1'b1;
      got_m |= mode_load_out === 1'b1;
    end
  endtask

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    {fails, n_compared, cycles, n_edge} = '0;
    beats = '{0, 0};
    keeps = '{0, 0};
    arst_n_in = 1'b0;
    clk_en_in = 1'b1;
    sref_request_in = 1'b0;
    {masks, strobes, rd_drive} = 6'h00;
    tick(12);
    arst_n_in = 1'b1;
    tick(8);
    for (int c = 0; c < 16; c++) begin
      send(4'(c), 2'h2, 14'h0033);
      check("valid", got_v, c < 7);
      check("mode load", got_m, c == 0);
      if (c < 7) check("cmd", snap[25:22], c);
    end
    check("mode sel", mode_sel_out, 2'h2);
    check("opcode", mode_opcode_out, 14'h0033);
    check("open", open_banks_out, 4'h4);
    $display("test codes done");
    for (int b = 0; b < 4; b++) begin
      send(LCAP_CMD_ACT, 2'(b), 14'h1abc);
      check("bank", snap[21:20], b);
      check("row", snap[19:6], 14'h1abc);
    end
    send(LCAP_CMD_RD, 2'h1, 14'h0405);
    check("auto pre", snap[5], 1'b1);
    check("column", snap[19:6], 14'h0405);
    check("open", open_banks_out, 4'hd);
    send(LCAP_CMD_PRE, 2'h3, 14'h0000);
    check("pre one", snap[4:0], 5'h08);
    send(LCAP_CMD_PRE, 2'h0, 14'h0400);
    check("pre all", snap[4:0], 5'h1f);
    check("open", open_banks_out, 4'h0);
    $display("test banks done");
    clk_en_in = 1'b0;
    tick(20);
    check("state", pwr_state_out, LCAP_PWR_PPD);
    check("run", {clocks_run_out, drivers_on_out}, 2'h0);
    send(LCAP_CMD_ACT, 2'h0, 14'h0000);
    check("ignored", got_v, 1'b0);
    clk_en_in = 1'b1;
    tick(20);
    check("run", {clocks_run_out, drivers_on_out}, 2'h3);
    send(LCAP_CMD_ACT, 2'h0, 14'h0000);
    clk_en_in = 1'b0;
    tick(20);
    check("state", pwr_state_out, LCAP_PWR_APD);
    clk_en_in = 1'b1;
    tick(20);
    send(LCAP_CMD_PRE, 2'h0, 14'h0400);
    sref_request_in = 1'b1;
    clk_en_in = 1'b0;
    tick(20);
    check("state", pwr_state_out, LCAP_PWR_SREF);
    clk_en_in = 1'b1;
    tick(20);
    check("state", pwr_state_out, LCAP_PWR_ACTIVE);
    $display("test power done");
    beats = '{0, 0};
    keeps = '{0, 0};
    for (int e = 0; e < 4; e++) begin
      masks = (e < 3) ? 2'h1 : 2'h2;
      tick(4);
      strobes = ~strobes;
      tick(8);
    end
    check("beats", beats[0] + beats[1], 8);
    check("keep lane0", keeps[0], 1);
    check("keep lane1", keeps[1], 3);
    rd_drive = 2'h2;
    tick(10);
    check("strobe oe", s_oe, 2'h2);
    rd_drive = 2'h0;
    tick(10);
    check("strobe oe", s_oe, 2'h0);
    n_edge = 0;
    n_sedge = 0;
    tick(80);
    check("edges", n_edge inside {[19:21]}, 1'b1);
    check("strobe edges", n_sedge inside {[19:21]}, 1'b1);
    $display("test lanes done");
    final_report;
  end
endmodule // tb_top
